// *** cwlo_divider.sv ***
`timescale 1ns/1ns
module cwlo_divider (
	input  wire logic        mclk_i,
	input  wire logic        resetn_i,
	input  wire logic        quad_rate_lo_clock_i,
	input  wire logic        lo_reset_i,
	input  wire logic [7:0]  chan_en_i,
	input  wire logic [31:0] phase_code_i,
	output logic      [7:0]  lo_i_o,
	output logic      [7:0]  lo_q_o,
	output logic      [15:0] lo_fine_o,
	output logic      [3:0]  lo_i_count_o,
	output logic      [1:0]  div_state_o
);
	localparam int NCH = cwlo_pkg::NUM_CH;
	localparam int CW  = cwlo_pkg::CODE_W;
	localparam int FW  = cwlo_pkg::FINE_W;

	logic            lo_clk_d_ff;
	logic            nxt_lo_clk_d;
	logic [1:0]      div_ff;
	logic [1:0]      nxt_div;
	logic            lo_rise;
	logic            upd;
	logic [NCH-1:0]  lo_i_ff;
	logic [NCH-1:0]  lo_q_ff;
	logic [NCH-1:0]  nxt_lo_i;
	logic [NCH-1:0]  nxt_lo_q;
	logic [NCH*FW-1:0] fine_ff;
	logic [NCH*FW-1:0] nxt_fine;
	logic [3:0]      cnt_ff;
	logic [3:0]      nxt_cnt;

	// edge of the quad-rate clock seen on the system clock
	// a quad-rate clock near half of mclk would alias and lose edges
	assign lo_rise = quad_rate_lo_clock_i & ~lo_clk_d_ff;
	assign upd     = lo_rise | lo_reset_i;

	always_comb begin
		nxt_lo_clk_d = quad_rate_lo_clock_i;
		nxt_div      = div_ff;
		if (lo_reset_i) begin
			nxt_div = cwlo_pkg::DIV_SYNC_STATE;
		end else if (lo_rise) begin
			nxt_div = div_ff + 2'h1;
		end
	end

	always_ff @(posedge mclk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			lo_clk_d_ff <= 1'b0;
			div_ff      <= cwlo_pkg::DIV_PWRUP_STATE;
		end else begin
			lo_clk_d_ff <= nxt_lo_clk_d;
			div_ff      <= nxt_div;
		end
	end

	// every channel rotates the one shared divider, never a private one
	genvar g;
	generate
		for (g = 0; g < NCH; g++) begin : g_ch
			logic [CW-1:0] code;
			logic [1:0]    rot;
			assign code = phase_code_i[g*CW +: CW];
			always_comb begin
				rot = nxt_div + code[cwlo_pkg::CODE_QUAD_MSB -: 2];
				nxt_lo_i[g] = lo_i_ff[g];
				nxt_lo_q[g] = lo_q_ff[g];
				nxt_fine[g*FW +: FW] = fine_ff[g*FW +: FW];
				if (upd) begin
					// gray decode: only one of I/Q moves per step
					nxt_lo_i[g] = chan_en_i[g] & rot[1];
					nxt_lo_q[g] = chan_en_i[g] & (rot[1] ^ rot[0]);
					// sub-quadrant 22.5 degree steps go to the mixer weights
					nxt_fine[g*FW +: FW] = code[1:0];
				end
			end
		end
	endgenerate

	// count the next I values so the sum lands together with the outputs
	always_comb begin
		nxt_cnt = cnt_ff;
		if (upd) begin
			nxt_cnt = 4'h0;
			for (int k = 0; k < NCH; k++) begin
				nxt_cnt = nxt_cnt + {3'h0, nxt_lo_i[k]};
			end
		end
	end

	// outputs change only on the LO edge or while lo_reset_i is high, so duty is set by the divider
	always_ff @(posedge mclk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			lo_i_ff <= '0;
			lo_q_ff <= '0;
			fine_ff <= '0;
			cnt_ff  <= 4'h0;
		end else begin
			lo_i_ff <= nxt_lo_i;
			lo_q_ff <= nxt_lo_q;
			fine_ff <= nxt_fine;
			cnt_ff  <= nxt_cnt;
		end
	end

	assign lo_i_o       = lo_i_ff;
	assign lo_q_o       = lo_q_ff;
	assign lo_fine_o    = fine_ff;
	assign lo_i_count_o = cnt_ff;
	assign div_state_o  = div_ff;

	// helper: code and enable that channel 0 last used
	logic [CW-1:0] last_code0_ff;
	logic          last_en0_ff;
	always_ff @(posedge mclk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			last_code0_ff <= 4'h0;
			last_en0_ff   <= 1'b0;
		end else if (upd) begin
			last_code0_ff <= phase_code_i[3:0];
			last_en0_ff   <= chan_en_i[0];
		end
	end

	// channels 0, 1 and 3 are watched singly; every channel shares one decode
	a_reset_forces_sync: assert property (@(posedge mclk_i)
		disable iff (!resetn_i)
		lo_reset_i |=> div_ff == cwlo_pkg::DIV_SYNC_STATE)
		else $error("divider not at sync state under reset");

	a_release_then_step: assert property (@(posedge mclk_i)
		disable iff (!resetn_i)
		$fell(lo_reset_i) && lo_rise |=> div_ff == 2'h1)
		else $error("divider did not restart on first LO edge");

	a_step_per_edge: assert property (@(posedge mclk_i)
		disable iff (!resetn_i)
		!lo_reset_i && lo_rise |=> div_ff == $past(div_ff) + 2'h1)
		else $error("divider did not advance one state");

	a_hold_no_edge: assert property (@(posedge mclk_i)
		disable iff (!resetn_i)
		!lo_reset_i && !lo_rise |=> $stable(div_ff))
		else $error("divider moved without LO edge");

	a_out_reclocked: assert property (@(posedge mclk_i)
		disable iff (!resetn_i)
		!upd |=> $stable(lo_i_o) && $stable(lo_q_o))
		else $error("LO outputs changed off the LO edge");

	a_iq_quarter: assert property (@(posedge mclk_i)
		disable iff (!resetn_i)
		lo_rise && !lo_reset_i && chan_en_i[0] && last_en0_ff
			&& phase_code_i[3:0] == last_code0_ff
		|=> (lo_i_o[0] != $past(lo_i_o[0]))
			!= (lo_q_o[0] != $past(lo_q_o[0])))
		else $error("I and Q not a quarter cycle apart");

	a_code_90_shift: assert property (@(posedge mclk_i)
		disable iff (!resetn_i)
		upd && chan_en_i[1:0] == 2'h3 && phase_code_i[3:0] == 4'h0
			&& phase_code_i[7:4] == 4'h4
		|=> lo_i_o[1] == lo_q_o[0])
		else $error("code 0100 not 90 degrees from code 0000");

	a_same_code_sync: assert property (@(posedge mclk_i)
		disable iff (!resetn_i)
		upd && chan_en_i[1:0] == 2'h3
			&& phase_code_i[3:0] == phase_code_i[7:4]
		|=> lo_i_o[0] == lo_i_o[1] && lo_q_o[0] == lo_q_o[1])
		else $error("equal codes gave unequal LO phase");

	a_fine_follows: assert property (@(posedge mclk_i)
		disable iff (!resetn_i)
		upd |=> lo_fine_o[1:0] == $past(phase_code_i[1:0]))
		else $error("fine step select not taken from code");

	a_sum_n_times: assert property (@(posedge mclk_i)
		disable iff (!resetn_i)
		upd && chan_en_i == 8'hff
			&& phase_code_i == {8{phase_code_i[3:0]}}
		|=> lo_i_count_o == (lo_i_o[0] ? 4'h8 : 4'h0))
		else $error("sum of equal channels is not N times one");

	a_iq_rotate: assert property (@(posedge mclk_i)
		disable iff (!resetn_i)
		lo_rise && !lo_reset_i && chan_en_i[0] && last_en0_ff
			&& phase_code_i[3:0] == last_code0_ff
		|=> lo_i_o[0] == $past(lo_q_o[0])
			&& lo_q_o[0] != $past(lo_i_o[0]))
		else $error("I and Q did not rotate by one quarter");

	a_dis_ch_low: assert property (@(posedge mclk_i)
		disable iff (!resetn_i)
		upd |=> ((lo_i_o | lo_q_o) & ~$past(chan_en_i)) == 8'h0)
		else $error("disabled channel drives its LO");

	a_count_matches: assert property (@(posedge mclk_i)
		disable iff (!resetn_i)
		upd |=> lo_i_count_o == 4'($countones(lo_i_o)))
		else $error("I count does not match the I outputs");

	a_sync_known_out: assert property (@(posedge mclk_i)
		disable iff (!resetn_i)
		lo_reset_i && chan_en_i[0] && phase_code_i[3:0] == 4'h0
		|=> !lo_i_o[0] && !lo_q_o[0])
		else $error("channel 0 not at zero phase under reset");

	a_side_outs_hold: assert property (@(posedge mclk_i)
		disable iff (!resetn_i)
		!upd |=> $stable(lo_fine_o) && $stable(lo_i_count_o))
		else $error("fine select or count changed off the LO edge");

	a_code_45_fine: assert property (@(posedge mclk_i)
		disable iff (!resetn_i)
		upd && phase_code_i[7:4] == 4'h2 |=> lo_fine_o[3:2] == 2'h2)
		else $error("code 0010 did not select the 45 degree step");

	a_code_135_shift: assert property (@(posedge mclk_i)
		disable iff (!resetn_i)
		upd && chan_en_i[3] && chan_en_i[0] && phase_code_i[3:0] == 4'h0
			&& phase_code_i[15:12] == 4'h6
		|=> lo_fine_o[7:6] == 2'h2 && lo_i_o[3] == lo_q_o[0])
		else $error("code 0110 not 135 degrees from code 0000");
endmodule

// *** cwlo_pkg.sv ***
// Summary of operation
// - after power-up the divider may sit in any of four quadrature states relative to other devices.
// - the I and Q LO of one device are always exactly a quarter LO cycle apart.
// - all channels share one divider, so their LO phases are synchronous without any reset.
// - reset is active high; on its fall the divider restarts at the next quad-rate LO rising edge.
// - against a channel coded 0000, codes 0010, 0100 and 0110 shift by 45, 90 and 135 degrees.
// - with equal codes and aligned dividers the sum of N channels equals N times one channel.
// - the 0 and 90 degree LO phases come digitally from dividing the quad-rate LO clock by four.
// - each channel offers sixteen phase settings of 22.5 degrees each over a full cycle, set by a 4-bit code.
// - the final LO output flops run on mclk and load on each sampled quad-rate LO rising edge, keeping 50 percent duty.
// - asserting reset forces the divider into one known fixed state.
package cwlo_pkg;
	localparam int        NUM_CH    = 8;
	localparam int        CODE_W    = 4;
	localparam int        FINE_W    = 2;
	localparam int        CNT_W     = 4;
	// state forced while reset is high; the common array reference
	localparam logic [1:0] DIV_SYNC_STATE = 2'h0;
	// arbitrary power-up state; real parts wake in any of the four
	localparam logic [1:0] DIV_PWRUP_STATE = 2'h2;
	localparam logic [1:0] CODE_QUAD_MSB  = 2'h3;
endpackage

// *** cwlo_ctrl_model.sv ***
`timescale 1ns/1ns
module cwlo_ctrl_model (
	input  wire logic mclk_i,
	output logic      qclk_o,
	output logic      rst_o
);
	initial begin
		qclk_o = 1'b0;
		rst_o  = 1'b0;
	end
	task automatic lo_edge();
		@(posedge mclk_i) #1 qclk_o = 1'b1;
		repeat (2) @(posedge mclk_i);
		#1 qclk_o = 1'b0;
		repeat (2) @(posedge mclk_i);
	endtask
	// pulse spans a whole lo period so it is far past the minimum width
	task automatic pulse_reset();
		@(posedge mclk_i) #1 rst_o = 1'b1;
		lo_edge();
		#1 rst_o = 1'b0;
	endtask
	// drop reset in the same step as the next rise; the divider steps at once
	task automatic release_on_edge();
		@(posedge mclk_i) #1 rst_o = 1'b1;
		repeat (2) @(posedge mclk_i);
		#1 rst_o = 1'b0;
		qclk_o = 1'b1;
		repeat (2) @(posedge mclk_i);
		#1 qclk_o = 1'b0;
		repeat (2) @(posedge mclk_i);
	endtask
endmodule

// *** cw_lo_divider_phase_sync_test.sv ***
`timescale 1ns/1ns
module cw_lo_divider_phase_sync_test;
	logic        mclk_i;
	logic        resetn_i;
	logic        qclk;
	logic        lrst;
	logic [7:0]  en;
	logic [7:0]  li;
	logic [7:0]  lq;
	logic [31:0] code;
	logic [15:0] fine;
	logic [3:0]  cnt;
	logic [1:0]  div;
	int          n_fail = 0;
	int          num_checks = 0;
	cwlo_divider dut (.mclk_i(mclk_i), .resetn_i(resetn_i),
		.quad_rate_lo_clock_i(qclk), .lo_reset_i(lrst), .chan_en_i(en),
		.phase_code_i(code), .lo_i_o(li), .lo_q_o(lq), .lo_fine_o(fine),
		.lo_i_count_o(cnt), .div_state_o(div));
	cwlo_ctrl_model ctl (.mclk_i(mclk_i), .qclk_o(qclk), .rst_o(lrst));
	task automatic check(input logic [19:0] s, input logic [19:0] e);
		num_checks++;
		if (s !== e) begin
			n_fail++;
			$display("Error at %0t: seen %h expected %h", $time, s, e);
		end
	endtask
	// {count, q, i} as the channels should show for divider state d
	function automatic logic [19:0] model(input logic [1:0] d);
		logic [1:0]  r;
		logic [19:0] v;
		v = '0;
		for (int n = 0; n < 8; n++) begin
			r = d + code[4*n+2 +: 2];
			v[n] = en[n] & r[1];
			v[8+n] = en[n] & (r[1] ^ r[0]);
			v[19:16] = v[19:16] + {3'h0, v[n]};
		end
		return v;
	endfunction
	task automatic expect_state(input logic [1:0] d);
		repeat (2) @(posedge mclk_i);
		#1;
		check({18'h0, div}, {18'h0, d});
		check({cnt, lq, li}, model(d));
	endtask
	task automatic t_walk();
		en = 8'hff;
		code = 32'heca86420;
		ctl.pulse_reset();
		expect_state(2'h0);
		check({4'h0, fine}, 20'h08888);
		for (int k = 1; k < 6; k++) begin
			ctl.lo_edge();
			expect_state(k[1:0]);
		end
	endtask
	// new codes must wait for the next lo edge
	task automatic t_hold();
		logic [19:0] e;
		e = model(2'h1);
		@(posedge mclk_i) #1 code = 32'h40;
		en = 8'h5b;
		repeat (4) @(posedge mclk_i);
		check({cnt, lq, li}, e);
		ctl.lo_edge();
		expect_state(2'h2);
	endtask
	task automatic t_sync();
		@(posedge mclk_i) #1 en = 8'hff;
		code = 32'h0;
		ctl.pulse_reset();
		expect_state(2'h0);
		ctl.lo_edge();
		ctl.lo_edge();
		expect_state(2'h2);
		check({16'h0, cnt}, 20'h8);
	endtask
	task automatic t_release();
		ctl.release_on_edge();
		expect_state(2'h1);
	endtask
	task automatic results();
		$display("checks %0d failures %0d", num_checks, n_fail);
		if (n_fail == 0 && num_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	initial begin
		mclk_i = 1'b0;
		forever #50 mclk_i = ~mclk_i;
	end
	initial begin
		resetn_i = 1'b0;
		en = 8'h0;
		code = 32'h0;
		repeat (6) @(posedge mclk_i);
		check({18'h0, div}, {18'h0, cwlo_pkg::DIV_PWRUP_STATE});
		#1 resetn_i = 1'b1;
		t_walk();
		t_hold();
		t_sync();
		t_release();
		results();
	end
	initial begin
		#100000;
		n_fail++;
		results();
	end
endmodule
